// ### crs_core_regs.sv
// crs core register set: accumulator, index, address, flags and stack sequencing
`timescale 1ns/1ns
module crs_core_regs (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // command from the instruction sequencer
  input wire crs_pkg::crs_cmd_s cmd,
  output logic busy,
  // stack memory port
  output logic stk_wr,
  output logic stk_rd,
  output logic [15:0] stk_addr,
  output logic [7:0] stk_wdata,
  input wire logic [7:0] stk_rdata,
  // register view
  output crs_pkg::crs_view_s view,
  output logic [7:0] index_value
);
  crs_pkg::crs_core_state_s r_reg, r_next;
  crs_pkg::crs_tgt_e tgt;
  logic take;
  logic push;
  logic pop;
  logic rsp;
  logic sp_load;
  logic [15:0] stack_ptr;
  logic [15:0] pop_addr;

  crs_stack_ptr u_sp (
    .clk(clk),
    .reset(reset),
    .push(push),
    .pop(pop),
    .rsp(rsp),
    .load(sp_load),
    .load_data(cmd.data),
    .stack_ptr(stack_ptr),
    .pop_addr(pop_addr)
  );

  // context byte order; restores walk the same table backwards
  function automatic crs_pkg::crs_tgt_e ctx_tgt(input logic [2:0] i);
    case (i)
      3'h0: ctx_tgt = crs_pkg::CRS_TGT_ADDR_LO;
      3'h1: ctx_tgt = crs_pkg::CRS_TGT_ADDR_HI;
      3'h2: ctx_tgt = crs_pkg::CRS_TGT_X;
      3'h3: ctx_tgt = crs_pkg::CRS_TGT_ACC;
      default: ctx_tgt = crs_pkg::CRS_TGT_FLAGS;
    endcase
  endfunction : ctx_tgt

  // write one byte into a register of the state copy
  function automatic crs_pkg::crs_core_state_s put(input crs_pkg::crs_core_state_s s,
                                                   input crs_pkg::crs_tgt_e t,
                                                   input logic [7:0] d);
    crs_pkg::crs_core_state_s o;
    o = s;
    case (t)
      crs_pkg::CRS_TGT_ACC: o.acc = d;
      crs_pkg::CRS_TGT_X: o.x = d;
      crs_pkg::CRS_TGT_Y: o.y = d;
      crs_pkg::CRS_TGT_FLAGS: o.flags = d | crs_pkg::CRS_FLAGS_FIXED;
      crs_pkg::CRS_TGT_ADDR_LO: o.instr_addr[7:0] = d;
      crs_pkg::CRS_TGT_ADDR_HI: o.instr_addr[15:8] = d;
      default: o = s;
    endcase
    return o;
  endfunction : put

  // read one byte of the register set
  function automatic logic [7:0] get(input crs_pkg::crs_core_state_s s,
                                     input logic [15:0] sp,
                                     input crs_pkg::crs_tgt_e t);
    case (t)
      crs_pkg::CRS_TGT_ACC: get = s.acc;
      crs_pkg::CRS_TGT_X: get = s.x;
      crs_pkg::CRS_TGT_Y: get = s.y;
      crs_pkg::CRS_TGT_FLAGS: get = s.flags;
      crs_pkg::CRS_TGT_ADDR_LO: get = s.instr_addr[7:0];
      crs_pkg::CRS_TGT_ADDR_HI: get = s.instr_addr[15:8];
      default: get = sp[7:0];
    endcase
  endfunction : get

  // command decode and context sequences; commands are taken only when idle
  always_comb begin
    r_next = r_reg;
    push = 1'b0;
    pop = 1'b0;
    rsp = 1'b0;
    sp_load = 1'b0;
    stk_wdata = 8'h00;
    take = (r_reg.seq == crs_pkg::CRS_SEQ_IDLE);
    tgt = cmd.tgt;
    if (r_reg.prefix && tgt == crs_pkg::CRS_TGT_X) begin
      tgt = crs_pkg::CRS_TGT_Y;
    end
    case (r_reg.seq)
      crs_pkg::CRS_SEQ_IDLE: begin
        if (cmd.op != crs_pkg::CRS_OP_NONE) begin
          r_next.prefix = (cmd.op == crs_pkg::CRS_OP_PREFIX);
        end
        // registers live only behind this decode, never at a memory address
        case (cmd.op)
          crs_pkg::CRS_OP_LOAD: begin
            if (tgt == crs_pkg::CRS_TGT_STACK_LO) begin
              sp_load = 1'b1;
            end else begin
              r_next = put(r_next, tgt, cmd.data);
            end
          end
          crs_pkg::CRS_OP_ALU: begin
            r_next = put(r_next, tgt, cmd.alu.res);
            if (cmd.alu.upd_nz) begin
              r_next.flags[crs_pkg::CRS_BIT_NEG] = cmd.alu.res[7];
              r_next.flags[crs_pkg::CRS_BIT_ZERO] = (cmd.alu.res == 8'h00);
            end
            if (cmd.alu.upd_h) begin
              r_next.flags[crs_pkg::CRS_BIT_HALF] = cmd.alu.half;
            end
            if (cmd.alu.upd_c) begin
              r_next.flags[crs_pkg::CRS_BIT_CARRY] = cmd.alu.carry;
            end
          end
          crs_pkg::CRS_OP_SET_CARRY: begin
            r_next.flags[crs_pkg::CRS_BIT_CARRY] = 1'b1;
          end
          crs_pkg::CRS_OP_RESET_CARRY: begin
            r_next.flags[crs_pkg::CRS_BIT_CARRY] = 1'b0;
          end
          // enable, wait and halt all drop to the main level so wakeups can arrive
          crs_pkg::CRS_OP_INT_ENABLE, crs_pkg::CRS_OP_WAIT_INT, crs_pkg::CRS_OP_HALT: begin
            r_next.flags[crs_pkg::CRS_BIT_PRIO_HI] = crs_pkg::CRS_PRIO_MAIN[1];
            r_next.flags[crs_pkg::CRS_BIT_PRIO_LO] = crs_pkg::CRS_PRIO_MAIN[0];
          end
          crs_pkg::CRS_OP_INT_DISABLE: begin
            r_next.flags[crs_pkg::CRS_BIT_PRIO_HI] = crs_pkg::CRS_PRIO_OFF[1];
            r_next.flags[crs_pkg::CRS_BIT_PRIO_LO] = crs_pkg::CRS_PRIO_OFF[0];
          end
          crs_pkg::CRS_OP_RESET_STACK: begin
            rsp = 1'b1;
          end
          crs_pkg::CRS_OP_JUMP: begin
            r_next.instr_addr = cmd.addr;
          end
          crs_pkg::CRS_OP_PUSH: begin
            push = 1'b1;
            stk_wdata = get(r_reg, stack_ptr, tgt);
          end
          crs_pkg::CRS_OP_POP: begin
            pop = 1'b1;
            r_next = put(r_next, tgt, stk_rdata);
          end
          crs_pkg::CRS_OP_CALL, crs_pkg::CRS_OP_INT_ENTRY: begin
            r_next.seq = crs_pkg::CRS_SEQ_SAVE;
            r_next.cnt = 3'h0;
            r_next.is_int = (cmd.op == crs_pkg::CRS_OP_INT_ENTRY);
            r_next.len = (cmd.op == crs_pkg::CRS_OP_CALL) ?
                         crs_pkg::CRS_CALL_BYTES : crs_pkg::CRS_INT_BYTES;
            r_next.target = cmd.addr;
            r_next.prio = cmd.data[1:0];
          end
          crs_pkg::CRS_OP_RETURN, crs_pkg::CRS_OP_INT_RETURN: begin
            r_next.seq = crs_pkg::CRS_SEQ_RESTORE;
            r_next.cnt = 3'h0;
            r_next.is_int = (cmd.op == crs_pkg::CRS_OP_INT_RETURN);
            r_next.len = (cmd.op == crs_pkg::CRS_OP_RETURN) ?
                         crs_pkg::CRS_CALL_BYTES : crs_pkg::CRS_INT_BYTES;
          end
          default: begin
          end
        endcase
      end
      // one byte per cycle, low address byte first at the free location
      crs_pkg::CRS_SEQ_SAVE: begin
        push = 1'b1;
        stk_wdata = get(r_reg, stack_ptr, ctx_tgt(r_reg.cnt));
        r_next.cnt = 3'(r_reg.cnt + 3'h1);
        if (r_reg.cnt == 3'(r_reg.len - 3'h1)) begin
          r_next.seq = crs_pkg::CRS_SEQ_IDLE;
          r_next.instr_addr = r_reg.target;
          if (r_reg.is_int) begin
            r_next.flags[crs_pkg::CRS_BIT_PRIO_HI] = r_reg.prio[1];
            r_next.flags[crs_pkg::CRS_BIT_PRIO_LO] = r_reg.prio[0];
          end
        end
      end
      // the second index register is never in the table, so it survives
      crs_pkg::CRS_SEQ_RESTORE: begin
        pop = 1'b1;
        r_next = put(r_next, ctx_tgt(3'(r_reg.len - 3'h1 - r_reg.cnt)), stk_rdata);
        r_next.cnt = 3'(r_reg.cnt + 3'h1);
        if (r_reg.cnt == 3'(r_reg.len - 3'h1)) begin
          r_next.seq = crs_pkg::CRS_SEQ_IDLE;
        end
      end
      default: begin
        r_next.seq = crs_pkg::CRS_SEQ_IDLE;
      end
    endcase
  end

  // upper flag bits come from CRS_FLAGS_FIXED and the reset pattern from CRS_CORE_RESET
  always_ff @(posedge clk) begin
    if (reset) begin
      r_reg <= crs_pkg::CRS_CORE_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  // stack port and register view
  assign busy = !take;
  assign stk_wr = push;
  assign stk_rd = pop;
  assign stk_addr = pop ? pop_addr : stack_ptr;
  assign view = '{acc: r_reg.acc, x: r_reg.x, y: r_reg.y, instr_addr: r_reg.instr_addr,
                  flags: r_reg.flags, stack_ptr: stack_ptr};
  assign index_value = r_reg.prefix ? r_reg.y : r_reg.x;

  property p_flags_reset;
    @(posedge clk) reset |=> view.flags == crs_pkg::CRS_FLAGS_RESET;
  endproperty
  a_flags_reset: assert property (p_flags_reset) else $error("flags reset wrong");

  property p_int_len;
    @(posedge clk) disable iff (reset)
      (!busy && cmd.op == crs_pkg::CRS_OP_INT_ENTRY) |=> (busy && stk_wr)[*5] ##1 !busy;
  endproperty
  a_int_len: assert property (p_int_len) else $error("interrupt save not five bytes");

  property p_call_len;
    @(posedge clk) disable iff (reset)
      (!busy && cmd.op == crs_pkg::CRS_OP_CALL) |=> (busy && stk_wr)[*2] ##1 !busy;
  endproperty
  a_call_len: assert property (p_call_len) else $error("call save not two bytes");

  property p_low_first;
    @(posedge clk) disable iff (reset)
      (!busy && cmd.op == crs_pkg::CRS_OP_INT_ENTRY)
      |=> stk_wdata == $past(view.instr_addr[7:0]) && stk_addr == $past(view.stack_ptr);
  endproperty
  a_low_first: assert property (p_low_first) else $error("low address byte not first");

  property p_prio_load;
    @(posedge clk) disable iff (reset)
      (!busy && cmd.op == crs_pkg::CRS_OP_INT_ENTRY)
      |-> ##6 {view.flags[crs_pkg::CRS_BIT_PRIO_HI], view.flags[crs_pkg::CRS_BIT_PRIO_LO]}
              == $past(cmd.data[1:0], 6);
  endproperty
  a_prio_load: assert property (p_prio_load) else $error("priority not loaded");

  property p_y_kept;
    @(posedge clk) disable iff (reset)
      busy |=> $stable(view.y);
  endproperty
  a_y_kept: assert property (p_y_kept) else $error("second index changed in sequence");

  property p_neg_zero;
    @(posedge clk) disable iff (reset)
      (!busy && cmd.op == crs_pkg::CRS_OP_ALU && cmd.alu.upd_nz)
      |=> view.flags[crs_pkg::CRS_BIT_NEG] == $past(cmd.alu.res[7])
          && view.flags[crs_pkg::CRS_BIT_ZERO] == ($past(cmd.alu.res) == 8'h00);
  endproperty
  a_neg_zero: assert property (p_neg_zero) else $error("negative or zero flag wrong");

  property p_half;
    @(posedge clk) disable iff (reset)
      (!busy && cmd.op == crs_pkg::CRS_OP_ALU && cmd.alu.upd_h)
      |=> view.flags[crs_pkg::CRS_BIT_HALF] == $past(cmd.alu.half);
  endproperty
  a_half: assert property (p_half) else $error("half carry wrong");

  property p_carry_cmd;
    @(posedge clk) disable iff (reset)
      (!busy && cmd.op == crs_pkg::CRS_OP_SET_CARRY) |=> view.flags[crs_pkg::CRS_BIT_CARRY];
  endproperty
  a_carry_cmd: assert property (p_carry_cmd) else $error("set carry failed");

  property p_disable;
    @(posedge clk) disable iff (reset)
      (!busy && cmd.op == crs_pkg::CRS_OP_INT_DISABLE)
      |=> view.flags[crs_pkg::CRS_BIT_PRIO_HI] && view.flags[crs_pkg::CRS_BIT_PRIO_LO];
  endproperty
  a_disable: assert property (p_disable) else $error("disable level not 11");

  property p_prefix;
    @(posedge clk) disable iff (reset)
      (!busy && cmd.op == crs_pkg::CRS_OP_PREFIX ##1
       !busy && cmd.op == crs_pkg::CRS_OP_LOAD && cmd.tgt == crs_pkg::CRS_TGT_X)
      |=> view.y == $past(cmd.data) && $stable(view.x);
  endproperty
  a_prefix: assert property (p_prefix) else $error("prefix did not select second index");
endmodule : crs_core_regs

// ### crs_pkg.sv
// crs register set: shared constants, command and view types
package crs_pkg;
  localparam logic [7:0] CRS_FLAGS_RESET = 8'he8;
  localparam logic [7:0] CRS_FLAGS_FIXED = 8'hc0;
  localparam logic [15:0] CRS_STACK_RESET = 16'h017f;
  localparam logic [15:0] CRS_STACK_BASE = 16'h0100;
  localparam logic [8:0] CRS_STACK_HI = 9'h002;
  localparam int CRS_BIT_HALF = 4;
  localparam int CRS_BIT_NEG = 2;
  localparam int CRS_BIT_ZERO = 1;
  localparam int CRS_BIT_CARRY = 0;
  localparam int CRS_BIT_PRIO_HI = 5;
  localparam int CRS_BIT_PRIO_LO = 3;
  localparam logic [1:0] CRS_PRIO_MAIN = 2'h2;
  localparam logic [1:0] CRS_PRIO_LVL1 = 2'h1;
  localparam logic [1:0] CRS_PRIO_LVL2 = 2'h0;
  localparam logic [1:0] CRS_PRIO_OFF = 2'h3;
  localparam logic [2:0] CRS_INT_BYTES = 3'h5;
  localparam logic [2:0] CRS_CALL_BYTES = 3'h2;

  typedef enum logic [4:0] {
    CRS_OP_NONE, CRS_OP_LOAD, CRS_OP_ALU, CRS_OP_SET_CARRY, CRS_OP_RESET_CARRY,
    CRS_OP_INT_ENABLE, CRS_OP_INT_DISABLE, CRS_OP_WAIT_INT, CRS_OP_HALT,
    CRS_OP_RESET_STACK, CRS_OP_JUMP, CRS_OP_PUSH, CRS_OP_POP, CRS_OP_CALL,
    CRS_OP_RETURN, CRS_OP_INT_ENTRY, CRS_OP_INT_RETURN, CRS_OP_PREFIX
  } crs_op_e;

  typedef enum logic [2:0] {
    CRS_TGT_ACC, CRS_TGT_X, CRS_TGT_Y, CRS_TGT_FLAGS, CRS_TGT_ADDR_LO,
    CRS_TGT_ADDR_HI, CRS_TGT_STACK_LO
  } crs_tgt_e;

  typedef enum logic [1:0] {CRS_SEQ_IDLE, CRS_SEQ_SAVE, CRS_SEQ_RESTORE} crs_seq_e;

  typedef struct packed {
    logic [7:0] res;
    logic carry;
    logic half;
    logic upd_nz;
    logic upd_h;
    logic upd_c;
  } crs_alu_s;

  typedef struct packed {
    crs_op_e op;
    crs_tgt_e tgt;
    logic [7:0] data;
    logic [15:0] addr;
    crs_alu_s alu;
  } crs_cmd_s;

  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] x;
    logic [7:0] y;
    logic [15:0] instr_addr;
    logic [7:0] flags;
    logic [15:0] stack_ptr;
  } crs_view_s;

  typedef struct packed {
    crs_seq_e seq;
    logic [2:0] cnt;
    logic [2:0] len;
    logic is_int;
    logic [15:0] target;
    logic [1:0] prio;
    logic prefix;
    logic [7:0] acc;
    logic [7:0] x;
    logic [7:0] y;
    logic [15:0] instr_addr;
    logic [7:0] flags;
  } crs_core_state_s;

  localparam crs_core_state_s CRS_CORE_RESET = '{
    seq: CRS_SEQ_IDLE, cnt: 3'h0, len: 3'h0, is_int: 1'b0, target: 16'h0000,
    prio: 2'h0, prefix: 1'b0, acc: 8'h00, x: 8'h00, y: 8'h00,
    instr_addr: 16'h0000, flags: CRS_FLAGS_RESET
  };

  typedef struct packed {
    logic [6:0] ofs;
  } crs_sp_state_s;
endpackage : crs_pkg

// ### crs_stack_ptr.sv
// crs stack pointer over a 128-byte stack with silent wrap
`timescale 1ns/1ns
module crs_stack_ptr (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // control from the core
  input wire logic push,
  input wire logic pop,
  input wire logic rsp,
  input wire logic load,
  input wire logic [7:0] load_data,
  // pointer outputs
  output logic [15:0] stack_ptr,
  output logic [15:0] pop_addr
);
  crs_pkg::crs_sp_state_s r_reg, r_next;

  // only the low seven bits move; the rest are fixed, so wrap is free
  always_comb begin
    r_next = r_reg;
    if (rsp) begin
      r_next.ofs = crs_pkg::CRS_STACK_RESET[6:0];
    end else if (load) begin
      r_next.ofs = load_data[6:0];
    end else if (push) begin
      r_next.ofs = 7'(r_reg.ofs - 7'h01);
    end else if (pop) begin
      r_next.ofs = 7'(r_reg.ofs + 7'h01);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      r_reg.ofs <= crs_pkg::CRS_STACK_RESET[6:0];
    end else begin
      r_reg <= r_next;
    end
  end

  // pointer names the next free byte; a pop reads one above it
  assign stack_ptr = {crs_pkg::CRS_STACK_HI, r_reg.ofs};
  assign pop_addr = {crs_pkg::CRS_STACK_HI, 7'(r_reg.ofs + 7'h01)};

  property p_sp_reset;
    @(posedge clk) reset |=> stack_ptr == crs_pkg::CRS_STACK_RESET;
  endproperty
  a_sp_reset: assert property (p_sp_reset) else $error("stack reset value wrong");

  property p_push_dec;
    @(posedge clk) disable iff (reset)
      (push && !rsp && !load) |=> stack_ptr[6:0] == 7'($past(stack_ptr[6:0]) - 7'h01);
  endproperty
  a_push_dec: assert property (p_push_dec) else $error("push did not decrement");

  property p_wrap;
    @(posedge clk) disable iff (reset)
      (push && !pop && !rsp && !load && stack_ptr == crs_pkg::CRS_STACK_BASE)
      |=> stack_ptr == crs_pkg::CRS_STACK_RESET;
  endproperty
  a_wrap: assert property (p_wrap) else $error("stack did not wrap to top");

  property p_rsp;
    @(posedge clk) disable iff (reset)
      rsp |=> stack_ptr == crs_pkg::CRS_STACK_RESET;
  endproperty
  a_rsp: assert property (p_rsp) else $error("stack reset command failed");
endmodule : crs_stack_ptr

// ### crs_stack_ram.sv
// stack memory model standing on the far side of the core's stack port
`timescale 1ns/1ns
module crs_stack_ram (
  // clock
  input wire logic clk,
  // stack port from the core
  input wire logic stk_wr,
  input wire logic stk_rd,
  input wire logic [15:0] stk_addr,
  input wire logic [7:0] stk_wdata,
  output logic [7:0] stk_rdata
);
  logic [7:0] mem [0:255];
  logic [7:0] last_reg;

  // byte writes land on the clock edge of the strobe
  always_ff @(posedge clk) begin
    if (stk_wr) begin
      mem[stk_addr[7:0]] <= stk_wdata;
    end
    if (stk_rd) begin
      last_reg <= mem[stk_addr[7:0]];
    end
  end

  // asynchronous read; unselected bus shows the inverse so stale data never looks right
  always_comb begin
    stk_rdata = stk_rd ? mem[stk_addr[7:0]] : ~last_reg;
  end
endmodule : crs_stack_ram

// ### testbench.sv
// self-checking bench for the core register set with stack memory model
`timescale 1ns/1ns
module testbench;
  logic clk = 1'b0;
  logic reset = 1'b1;
  crs_pkg::crs_cmd_s cmd = '0;
  logic busy, stk_wr, stk_rd;
  logic [15:0] stk_addr;
  logic [7:0] stk_wdata, stk_rdata, index_value;
  crs_pkg::crs_view_s view;
  int err_total = 0;
  int n_checks = 0;
  int seed = 19750;
  logic [23:0] exp_q[$];
  logic [7:0] ea, ex, ey, ef, sf, b;
  logic [8:0] sum;
  logic [15:0] pa;

  crs_core_regs crs_core_regs_i (.clk(clk), .reset(reset), .cmd(cmd), .busy(busy),
    .stk_wr(stk_wr), .stk_rd(stk_rd), .stk_addr(stk_addr), .stk_wdata(stk_wdata),
    .stk_rdata(stk_rdata), .view(view), .index_value(index_value));
  crs_stack_ram crs_stack_ram_i (.clk(clk), .stk_wr(stk_wr), .stk_rd(stk_rd),
    .stk_addr(stk_addr), .stk_wdata(stk_wdata), .stk_rdata(stk_rdata));

  // free-running clock, 100 MHz
  always #5 clk = ~clk;

  task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
    n_checks++;
    if (seen !== exp) begin
      $display("ERROR %s expected %h seen %h", name, exp, seen);
      err_total++;
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test

  // present a command for one edge, count its busy cycles with a bound, then let an edge
  // pass so the next command is never written in the same step as this clear
  task automatic issue(input crs_pkg::crs_op_e op, input crs_pkg::crs_tgt_e tgt,
                       input logic [7:0] d, input logic [15:0] a, input crs_pkg::crs_alu_s alu);
    int n = 0;
    int len = 0;
    if (op == crs_pkg::CRS_OP_INT_ENTRY || op == crs_pkg::CRS_OP_INT_RETURN) begin
      len = 5;
    end else if (op == crs_pkg::CRS_OP_CALL || op == crs_pkg::CRS_OP_RETURN) begin
      len = 2;
    end
    cmd = '{op: op, tgt: tgt, data: d, addr: a, alu: alu};
    @(negedge clk);
    cmd = '0;
    while (busy !== 1'b0 && n < 20) begin
      @(negedge clk);
      n++;
    end
    check("busy cycles", 24'(n), 24'(len));
    @(negedge clk);
  endtask : issue

  task automatic op1(input crs_pkg::crs_op_e op, input crs_pkg::crs_tgt_e tgt,
                     input logic [7:0] d);
    issue(op, tgt, d, 16'h0000, '0);
  endtask : op1

  // monitor: every stack write strobe takes the oldest expected write off the queue
  always @(posedge clk) begin
    if (!reset && stk_wr === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("unexpected stack write", {stk_addr, stk_wdata}, 24'h0);
      end else begin
        check("stack write", {stk_addr, stk_wdata}, exp_q.pop_front());
      end
    end
  end

  // watchdog cuts a hang short
  initial begin
    #200000;
    err_total++;
    finish_test();
  end

  initial begin
    crs_pkg::crs_op_e pops[6];
    logic [1:0] pexp[6];
    pops = '{crs_pkg::CRS_OP_INT_DISABLE, crs_pkg::CRS_OP_INT_ENABLE,
      crs_pkg::CRS_OP_INT_DISABLE, crs_pkg::CRS_OP_WAIT_INT,
      crs_pkg::CRS_OP_INT_DISABLE, crs_pkg::CRS_OP_HALT};
    pexp = '{2'h3, 2'h2, 2'h3, 2'h2, 2'h3, 2'h2};
    repeat (16) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    ef = 8'he8;
    check("flags reset", view.flags, ef);
    check("stack reset", view.stack_ptr, 16'h017f);
    // loads into every data register, flags write forces the two top bits
    ea = 8'($random(seed));
    ex = 8'($random(seed));
    ey = 8'($random(seed));
    pa = 16'($random(seed));
    op1(crs_pkg::CRS_OP_LOAD, crs_pkg::CRS_TGT_ACC, ea);
    op1(crs_pkg::CRS_OP_LOAD, crs_pkg::CRS_TGT_X, ex);
    check("index plain", index_value, ex);
    // prefix and the load it steers go back to back, with no idle command between them
    cmd = '{op: crs_pkg::CRS_OP_PREFIX, tgt: crs_pkg::CRS_TGT_ACC, data: 8'h00,
           addr: 16'h0000, alu: '0};
    @(negedge clk);
    check("index under prefix", index_value, 8'h00);
    cmd = '{op: crs_pkg::CRS_OP_LOAD, tgt: crs_pkg::CRS_TGT_X, data: ey,
           addr: 16'h0000, alu: '0};
    @(negedge clk);
    cmd = '0;
    @(negedge clk);
    op1(crs_pkg::CRS_OP_LOAD, crs_pkg::CRS_TGT_ADDR_LO, pa[7:0]);
    op1(crs_pkg::CRS_OP_LOAD, crs_pkg::CRS_TGT_ADDR_HI, pa[15:8]);
    op1(crs_pkg::CRS_OP_LOAD, crs_pkg::CRS_TGT_FLAGS, 8'h15);
    ef = 8'hd5;
    check("acc", view.acc, ea);
    check("x kept", view.x, ex);
    check("y via prefix", view.y, ey);
    check("instr addr", view.instr_addr, pa);
    check("flags write", view.flags, ef);
    // alu results, first one wraps to zero
    for (int i = 0; i < 6; i++) begin
      b = 8'($random(seed));
      if (i == 0) b = -ea;
      sum = ea + b;
      ef[4] = (ea[3:0] + b[3:0]) > 5'h0f;
      ef[2] = sum[7];
      ef[1] = (sum[7:0] == 8'h00);
      ef[0] = sum[8];
      issue(crs_pkg::CRS_OP_ALU, crs_pkg::CRS_TGT_ACC, 8'h00, 16'h0000,
        '{res: sum[7:0], carry: sum[8], half: ef[4], upd_nz: 1'b1, upd_h: 1'b1, upd_c: 1'b1});
      ea = sum[7:0];
      check("alu flags", view.flags, ef);
    end
    op1(crs_pkg::CRS_OP_SET_CARRY, crs_pkg::CRS_TGT_ACC, 8'h00);
    check("set carry", view.flags[0], 1'b1);
    op1(crs_pkg::CRS_OP_RESET_CARRY, crs_pkg::CRS_TGT_ACC, 8'h00);
    check("reset carry", view.flags[0], 1'b0);
    ef[0] = 1'b0;
    for (int i = 0; i < 6; i++) begin
      op1(pops[i], crs_pkg::CRS_TGT_ACC, 8'h00);
      {ef[5], ef[3]} = pexp[i];
      check("priority", view.flags, ef);
    end
    // interrupt entry saves five bytes downward, y untouched
    sf = ef;
    exp_q.push_back({16'h017f, pa[7:0]});
    exp_q.push_back({16'h017e, pa[15:8]});
    exp_q.push_back({16'h017d, ex});
    exp_q.push_back({16'h017c, ea});
    exp_q.push_back({16'h017b, sf});
    issue(crs_pkg::CRS_OP_INT_ENTRY, crs_pkg::CRS_TGT_ACC, 8'h01, 16'habcd, '0);
    check("int stack", view.stack_ptr, 16'h017a);
    check("vector", view.instr_addr, 16'habcd);
    check("int prio", {view.flags[5], view.flags[3]}, 2'h1);
    op1(crs_pkg::CRS_OP_LOAD, crs_pkg::CRS_TGT_ACC, ~ea);
    op1(crs_pkg::CRS_OP_LOAD, crs_pkg::CRS_TGT_X, ~ex);
    op1(crs_pkg::CRS_OP_INT_RETURN, crs_pkg::CRS_TGT_ACC, 8'h00);
    check("ret acc", view.acc, ea);
    check("ret x", view.x, ex);
    check("ret y", view.y, ey);
    check("ret addr", view.instr_addr, pa);
    check("ret flags", view.flags, sf);
    check("ret stack", view.stack_ptr, 16'h017f);
    // call pushes two bytes, return restores them
    exp_q.push_back({16'h017f, pa[7:0]});
    exp_q.push_back({16'h017e, pa[15:8]});
    issue(crs_pkg::CRS_OP_CALL, crs_pkg::CRS_TGT_ACC, 8'h00, 16'h1234, '0);
    check("call stack", view.stack_ptr, 16'h017d);
    check("call target", view.instr_addr, 16'h1234);
    op1(crs_pkg::CRS_OP_RETURN, crs_pkg::CRS_TGT_ACC, 8'h00);
    check("return addr", view.instr_addr, pa);
    check("return stack", view.stack_ptr, 16'h017f);
    issue(crs_pkg::CRS_OP_JUMP, crs_pkg::CRS_TGT_ACC, 8'h00, 16'h4321, '0);
    check("jump", view.instr_addr, 16'h4321);
    // push and pop move the pointer around the next free byte
    exp_q.push_back({16'h017f, ex});
    op1(crs_pkg::CRS_OP_PUSH, crs_pkg::CRS_TGT_X, 8'h00);
    check("push sp", view.stack_ptr, 16'h017e);
    op1(crs_pkg::CRS_OP_POP, crs_pkg::CRS_TGT_ACC, 8'h00);
    check("pop acc", view.acc, ex);
    check("pop sp", view.stack_ptr, 16'h017f);
    // silent wrap at both limits, low byte bit 7 is not writable
    op1(crs_pkg::CRS_OP_LOAD, crs_pkg::CRS_TGT_STACK_LO, 8'h80);
    check("load sp", view.stack_ptr, 16'h0100);
    exp_q.push_back({16'h0100, ex});
    op1(crs_pkg::CRS_OP_PUSH, crs_pkg::CRS_TGT_ACC, 8'h00);
    check("push wrap", view.stack_ptr, 16'h017f);
    op1(crs_pkg::CRS_OP_LOAD, crs_pkg::CRS_TGT_ACC, 8'h00);
    op1(crs_pkg::CRS_OP_POP, crs_pkg::CRS_TGT_ACC, 8'h00);
    check("pop wrap data", view.acc, ex);
    check("pop wrap sp", view.stack_ptr, 16'h0100);
    op1(crs_pkg::CRS_OP_RESET_STACK, crs_pkg::CRS_TGT_ACC, 8'h00);
    check("reset stack", view.stack_ptr, 16'h017f);
    check("writes pending", 24'(exp_q.size()), 24'h0);
    finish_test();
  end
endmodule : testbench
